// ==== logic/speed_run_defs.vh ====
// constants for the speed step and run command selector
// assumes a 100 MHz ref_clk
`ifndef SPEED_RUN_DEFS_VH
`define SPEED_RUN_DEFS_VH
`define FN_STEP_BIT1      5'h03
`define FN_STEP_BIT2      5'h04
`define FN_STEP_BIT3      5'h05
`define FN_JOG_SELECT     5'h06
`define FN_THREE_WIRE     5'h00
`define AUX_FN_SWITCH     5'h02
`define AN2_FN_ANALOG     5'h02
`define AN3_FN_ANALOG     5'h03
`define AN_FN_UNUSED      5'h1f
`define SPD_SRC_KEYPAD    3'h0
`define SPD_SRC_ANALOG    3'h1
`define RUN_SRC_KEYPAD    2'h0
`define RUN_SRC_TERMINAL  2'h1
`define RUN_SRC_SERIAL    2'h2
`define RUN_SRC_OPTION    2'h3
`define RUN_SRC_RESET     2'h1
`define REF_W             16
`define STEP_COUNT        17
`define STORED_COUNT      16
`define RUN_HOLD_MS       50
`define CLK_MHZ           100
`define RUN_HOLD_CYCLES   (`RUN_HOLD_MS * 1000 * `CLK_MHZ)
`endif

// ==== logic/pin_sync.v ====
// three-stage synchroniser with agreement filter for one contact input
// assumes d comes from outside the ref_clk domain
`timescale 1ns/1ps
module pin_sync (
  input  wire ref_clk,
  input  wire rst,
  input  wire d,
  output reg  q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge ref_clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q    <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule

// ==== logic/speed_step_and_run_command_select.v ====
// speed step and run command selector of a motor drive
// assumes configuration ports are static while running; contacts are asynchronous
//
// What this block does
// - nine speeds: the first eight of sixteen stored references plus one jog reference.
// - input function codes 3, 4, 5 make step bits 1, 2, 3.
// - function code 6 is jog select; jog wins over step bits.
// - step bits form binary index, bit 1 lowest; all off is reference 1.
// - analog function 2 lets step bit 1 switch master and auxiliary.
// - step 1 uses first analog when speed source 1, stored when 0.
// - step 2 uses second analog when its function is 2, stored at 1F.
// - step 3 uses third analog when its function is 3, stored at 1F.
// - run source 0..3, default 1: keypad, terminals, serial, option card.
// - run source 0 takes run, stop, jog, direction only from keypad.
// - two-wire: run forward while first run input alone on, stop when off or both on.
// - two-wire: run reverse while second run input alone on, stop when off or both on.
// - any input with code 0 selects three-wire run, stop, direction.
// - three-wire initialisation puts direction function on input 3.
// - run held long enough stays latched after the input returns off.
// - with analog function 2 and step bits 2, 3 off: master reference while step bit 1 off, auxiliary while on.
`timescale 1ns/1ps
`include "speed_run_defs.vh"
module speed_step_and_run_command_select #(
  parameter RUN_HOLD_CYCLES = `RUN_HOLD_CYCLES
) (
  input  wire                       ref_clk,
  input  wire                       rst,
  input  wire                       run_fwd_input,
  input  wire                       run_rev_or_stop_input,
  input  wire                       multi_input3,
  input  wire                       multi_input4,
  input  wire                       step_bit1_input,
  input  wire                       step_bit2_input,
  input  wire                       step_bit3_input,
  input  wire                       jog_select_input,
  input  wire [4:0]                 input3_function_setting,
  input  wire [4:0]                 input4_function_setting,
  input  wire [4:0]                 input5_function_setting,
  input  wire [4:0]                 input6_function_setting,
  input  wire [4:0]                 input7_function_setting,
  input  wire [4:0]                 input8_function_setting,
  input  wire                       init_three_wire,
  input  wire [4:0]                 analog2_function_setting,
  input  wire [4:0]                 analog3_function_setting,
  input  wire [2:0]                 speed_source_setting,
  input  wire [1:0]                 run_source_setting,
  input  wire                       run_source_load,
  input  wire [`REF_W*16-1:0]       stored_speed_refs,
  input  wire [`REF_W-1:0]          jog_speed_ref,
  input  wire [`REF_W-1:0]          analog_in_first,
  input  wire [`REF_W-1:0]          analog_in_second,
  input  wire [`REF_W-1:0]          analog_in_third,
  input  wire                       key_run,
  input  wire                       key_stop,
  input  wire                       key_jog,
  input  wire                       key_dir_rev,
  input  wire                       serial_run,
  input  wire                       serial_rev,
  input  wire                       option_run,
  input  wire                       option_rev,
  output reg  [`REF_W-1:0]          speed_ref_out,
  output reg  [4:0]                 speed_step_out,
  output reg                        jog_active,
  output reg                        run_cmd,
  output reg                        dir_reverse,
  output reg                        three_wire_mode,
  output reg  [1:0]                 run_source_q,
  output reg  [4:0]                 input3_function_q
);
  //////////////////////////////////////////////////////////////////////////////
  // synchronised contacts
  wire s_fwd;
  wire s_rev;
  wire s_m3;
  wire s_m4;
  wire s_b1;
  wire s_b2;
  wire s_b3;
  wire s_jog;
  pin_sync u_fwd (.ref_clk(ref_clk), .rst(rst), .d(run_fwd_input), .q(s_fwd));
  pin_sync u_rev (.ref_clk(ref_clk), .rst(rst), .d(run_rev_or_stop_input), .q(s_rev));
  pin_sync u_m3  (.ref_clk(ref_clk), .rst(rst), .d(multi_input3), .q(s_m3));
  pin_sync u_m4  (.ref_clk(ref_clk), .rst(rst), .d(multi_input4), .q(s_m4));
  pin_sync u_b1  (.ref_clk(ref_clk), .rst(rst), .d(step_bit1_input), .q(s_b1));
  pin_sync u_b2  (.ref_clk(ref_clk), .rst(rst), .d(step_bit2_input), .q(s_b2));
  pin_sync u_b3  (.ref_clk(ref_clk), .rst(rst), .d(step_bit3_input), .q(s_b3));
  pin_sync u_jog (.ref_clk(ref_clk), .rst(rst), .d(jog_select_input), .q(s_jog));

  // level of the function code among the six terminals
  function fn_level;
    input [4:0] code;
    input [4:0] f3, f4, f5, f6, f7, f8;
    input       l3, l4, l5, l6, l7, l8;
    begin
      fn_level = (f3 == code && l3) | (f4 == code && l4) | (f5 == code && l5) |
                 (f6 == code && l6) | (f7 == code && l7) | (f8 == code && l8);
    end
  endfunction

  function fn_used;
    input [4:0] code;
    input [4:0] f3, f4, f5, f6, f7, f8;
    begin
      fn_used = (f3 == code) | (f4 == code) | (f5 == code) |
                (f6 == code) | (f7 == code) | (f8 == code);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // speed selection
  wire bit1 = fn_level(`FN_STEP_BIT1, input3_function_q, input4_function_setting,
    input5_function_setting, input6_function_setting, input7_function_setting,
    input8_function_setting, s_m3, s_m4, s_b1, s_b2, s_b3, s_jog);
  wire bit2 = fn_level(`FN_STEP_BIT2, input3_function_q, input4_function_setting,
    input5_function_setting, input6_function_setting, input7_function_setting,
    input8_function_setting, s_m3, s_m4, s_b1, s_b2, s_b3, s_jog);
  wire bit3 = fn_level(`FN_STEP_BIT3, input3_function_q, input4_function_setting,
    input5_function_setting, input6_function_setting, input7_function_setting,
    input8_function_setting, s_m3, s_m4, s_b1, s_b2, s_b3, s_jog);
  wire jog_sel = fn_level(`FN_JOG_SELECT, input3_function_q, input4_function_setting,
    input5_function_setting, input6_function_setting, input7_function_setting,
    input8_function_setting, s_m3, s_m4, s_b1, s_b2, s_b3, s_jog);
  wire three_wire = fn_used(`FN_THREE_WIRE, input3_function_q, input4_function_setting,
    input5_function_setting, input6_function_setting, input7_function_setting,
    input8_function_setting);
  wire dir_in = fn_level(`FN_THREE_WIRE, input3_function_q, input4_function_setting,
    input5_function_setting, input6_function_setting, input7_function_setting,
    input8_function_setting, s_m3, s_m4, s_b1, s_b2, s_b3, s_jog);

  wire [3:0] idx = {1'b0, bit3, bit2, bit1};
  reg  [`REF_W-1:0] ref_d;
  reg  [4:0]        step_d;

  always @* begin
    ref_d  = stored_speed_refs[idx*`REF_W +: `REF_W];
    step_d = {1'b0, idx};
    if (jog_sel) begin
      ref_d  = jog_speed_ref;
      step_d = 5'h10;
    end else if (analog2_function_setting == `AUX_FN_SWITCH && !bit2 && !bit3) begin
      // master while bit 1 off, auxiliary while on
      if (bit1) begin
        ref_d = analog_in_second;
      end else if (speed_source_setting == `SPD_SRC_ANALOG) begin
        ref_d = analog_in_first;
      end
    end else if (idx == 4'h0) begin
      if (speed_source_setting == `SPD_SRC_ANALOG) begin
        ref_d = analog_in_first;
      end
    end else if (idx == 4'h1) begin
      if (analog2_function_setting == `AN2_FN_ANALOG) begin
        ref_d = analog_in_second;
      end
    end else if (idx == 4'h2) begin
      if (analog3_function_setting == `AN3_FN_ANALOG) begin
        ref_d = analog_in_third;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // run command source and sequences
  localparam [31:0] HOLD_LAST = RUN_HOLD_CYCLES - 1;
  reg  [31:0] hold_cnt_q;
  reg         latch_q;
  reg         run_d;
  reg         rev_d;
  wire        hold_done = (hold_cnt_q == HOLD_LAST);
  reg         key_latch_q;
  wire        key_latch_d = (key_latch_q | key_run) & ~key_stop;

  always @(posedge ref_clk) begin
    if (rst) begin
      hold_cnt_q <= 32'h0;
      latch_q    <= 1'b0;
    end else if (!three_wire || !s_rev) begin
      hold_cnt_q <= 32'h0;
      latch_q    <= 1'b0;
    end else if (s_fwd) begin
      if (hold_done) begin
        latch_q <= 1'b1;
      end else begin
        hold_cnt_q <= hold_cnt_q + 32'h1;
      end
    end else begin
      hold_cnt_q <= 32'h0;
    end
  end

  // keypad latch holds only what the keys set, so a run from another source is not kept
  always @(posedge ref_clk) begin
    if (rst || run_source_q != `RUN_SRC_KEYPAD) begin
      key_latch_q <= 1'b0;
    end else begin
      key_latch_q <= key_latch_d;
    end
  end

  always @* begin
    run_d = 1'b0;
    rev_d = dir_reverse;
    case (run_source_q)
      `RUN_SRC_KEYPAD: begin
        run_d = (key_latch_d | key_jog) & ~key_stop;
        rev_d = key_dir_rev;
      end
      `RUN_SRC_TERMINAL: begin
        if (three_wire) begin
          run_d = latch_q;
          rev_d = dir_in;
        end else if (s_fwd && !s_rev) begin
          run_d = 1'b1;
          rev_d = 1'b0;
        end else if (s_rev && !s_fwd) begin
          run_d = 1'b1;
          rev_d = 1'b1;
        end
      end
      `RUN_SRC_SERIAL: begin
        run_d = serial_run;
        rev_d = serial_rev;
      end
      `RUN_SRC_OPTION: begin
        run_d = option_run;
        rev_d = option_rev;
      end
      default: begin
        run_d = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      speed_ref_out     <= {`REF_W{1'b0}};
      speed_step_out    <= 5'h00;
      jog_active        <= 1'b0;
      run_cmd           <= 1'b0;
      dir_reverse       <= 1'b0;
      three_wire_mode   <= 1'b0;
      run_source_q      <= `RUN_SRC_RESET;
      input3_function_q <= `FN_STEP_BIT1;
    end else begin
      speed_ref_out   <= ref_d;
      speed_step_out  <= step_d;
      jog_active      <= jog_sel;
      run_cmd         <= run_d;
      dir_reverse     <= rev_d;
      three_wire_mode <= three_wire;
      if (run_source_load) begin
        run_source_q <= run_source_setting;
      end
      if (init_three_wire) begin
        input3_function_q <= `FN_THREE_WIRE;
      end else begin
        input3_function_q <= input3_function_setting;
      end
    end
  end
endmodule

// ==== verification/speed_run_sva.sv ====
// checker of selection outputs against contact and setting inputs
// assumes terminals 5..8 keep the step and jog functions 3..6
`timescale 1ns/1ps
module speed_run_sva (
  input wire         ref_clk,
  input wire         rst,
  input wire         run_fwd_input,
  input wire         run_rev_or_stop_input,
  input wire         step_bit1_input,
  input wire         step_bit2_input,
  input wire         step_bit3_input,
  input wire         jog_select_input,
  input wire         init_three_wire,
  input wire [1:0]   run_source_setting,
  input wire         run_source_load,
  input wire [255:0] stored_speed_refs,
  input wire [15:0]  jog_speed_ref,
  input wire         key_stop,
  input wire [15:0]  speed_ref_out,
  input wire [4:0]   speed_step_out,
  input wire         jog_active,
  input wire         run_cmd,
  input wire         three_wire_mode,
  input wire [1:0]   run_source_q,
  input wire [4:0]   input3_function_q
);
  ////////////////////////////////////////
  // settled: no contact or reference change for more than three edges
  wire [277:0] watch = {jog_select_input, step_bit3_input, step_bit2_input, step_bit1_input,
                        run_rev_or_stop_input, run_fwd_input, jog_speed_ref, stored_speed_refs};
  reg  [277:0] watch_q;
  reg  [3:0]   quiet_q;
  wire [2:0]   idx = {step_bit3_input, step_bit2_input, step_bit1_input};
  wire         settled = quiet_q > 4'h3 && watch == watch_q;
  wire         two_w = !three_wire_mode && run_source_q == 2'h1;
  always @(posedge ref_clk) begin
    watch_q <= watch;
    if (rst || watch != watch_q) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  jog_wins_a: assert property (settled && jog_select_input |-> jog_active
    && speed_step_out == 5'h10 && speed_ref_out == jog_speed_ref) else $error("jog not chosen");
  step_index_a: assert property (settled && !jog_select_input |-> !jog_active
    && speed_step_out == {2'h0, idx}) else $error("step index wrong");
  stored_ref_a: assert property (settled && !jog_select_input && idx > 3'h2
    |-> speed_ref_out == stored_speed_refs[idx*16 +: 16]) else $error("stored ref wrong");
  two_wire_a: assert property (settled && two_w ##1 settled && two_w
    |-> run_cmd == (run_fwd_input ^ run_rev_or_stop_input)) else $error("two-wire run wrong");
  stop_open_a: assert property (settled ##1 settled && three_wire_mode
    && !run_rev_or_stop_input |-> !run_cmd) else $error("run with stop open");
  keypad_stop_a: assert property (run_source_q == 2'h0 && key_stop |=> !run_cmd)
    else $error("keypad stop ignored");
  init_dir_a: assert property (init_three_wire |=> input3_function_q == 5'h00)
    else $error("input 3 not direction");
  src_load_a: assert property (run_source_load |=>
    run_source_q == $past(run_source_setting)) else $error("run source not loaded");
  cover property (settled && jog_select_input);
  cover property (three_wire_mode && run_cmd);
  cover property (run_source_q == 2'h0 && run_cmd);
endmodule

// ==== verification/contact_model.sv ====
// contact model: each terminal chatters once on every change
// assumes want is set by the bench just after a ref_clk edge
`timescale 1ns/1ps
module contact_model #(
  parameter HOLD = 20
) (
  input  wire       ref_clk,
  input  wire [7:0] want,
  input  wire       run_pulse,
  output reg  [7:0] pins
);
  reg  [7:0] cur_q;
  reg  [7:0] prev_q;
  reg        glitch_q;
  reg  [7:0] hold_q;
  wire [7:0] eff = want | {7'h0, hold_q != 8'h0};
  initial {pins, cur_q, prev_q, glitch_q, hold_q} = 33'h0;
  always @(posedge ref_clk) begin
    hold_q   <= run_pulse ? 8'(HOLD + 8) : hold_q - {7'h0, hold_q != 8'h0};
    glitch_q <= eff != cur_q;
    cur_q    <= eff;
    prev_q   <= cur_q;
    pins     <= glitch_q ? prev_q : eff;
  end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the speed step and run command selector
// assumes the contact model drives all eight terminals
`timescale 1ns/1ps
`include "speed_run_defs.vh"
module tb_top;
  reg          ref_clk, rst, run_pulse, run_source_load, init_three_wire;
  reg  [7:0]   want;
  wire [7:0]   pins;
  reg  [4:0]   input3_function_setting, input4_function_setting, input5_function_setting,
               input6_function_setting, input7_function_setting, input8_function_setting,
               analog2_function_setting, analog3_function_setting;
  reg  [2:0]   speed_source_setting;
  reg  [1:0]   run_source_setting;
  reg          key_run, key_stop, key_jog, key_dir_rev;
  reg          serial_run, serial_rev, option_run, option_rev;
  reg  [255:0] stored_speed_refs;
  reg  [15:0]  jog_speed_ref, analog_in_first, analog_in_second, analog_in_third;
  wire [15:0]  speed_ref_out;
  wire [4:0]   speed_step_out, input3_function_q;
  wire [1:0]   run_source_q;
  wire         jog_active, run_cmd, dir_reverse, three_wire_mode;
  reg  [31:0]  seed, bad_count, check_count, cycles;
  reg  [20:0]  e;
  integer      i;
  speed_step_and_run_command_select #(.RUN_HOLD_CYCLES(20)) dut (.*, .run_fwd_input(pins[0]),
    .run_rev_or_stop_input(pins[1]), .multi_input3(pins[2]), .multi_input4(pins[3]),
    .step_bit1_input(pins[4]), .step_bit2_input(pins[5]), .step_bit3_input(pins[6]),
    .jog_select_input(pins[7]));
  contact_model #(.HOLD(20)) model (.ref_clk(ref_clk), .want(want), .run_pulse(run_pulse),
    .pins(pins));
  ////////////////////////////////////////
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // expected {step, reference} for a terminal pattern
  function [20:0] pick(input [7:0] w);
    reg [2:0] k;
    begin
      k = w[6:4];
      pick = {2'h0, k, stored_speed_refs[k*16 +: 16]};
      if (k == 3'h0 && speed_source_setting == `SPD_SRC_ANALOG) pick[15:0] = analog_in_first;
      if (k == 3'h1 && analog2_function_setting == `AN2_FN_ANALOG) pick[15:0] = analog_in_second;
      if (k == 3'h2 && analog3_function_setting == `AN3_FN_ANALOG) pick[15:0] = analog_in_third;
      if (w[7]) pick = {5'h10, jog_speed_ref};
    end
  endfunction
  task chk(input string name, input [15:0] exp, got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task test_done;
    begin
      if (bad_count == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  initial begin
    {rst, want, run_pulse, seed, bad_count, check_count, cycles} = {10'h200, 32'hc930, 96'h0};
    {input3_function_setting, input4_function_setting} = {5'h0f, 5'h0f};
    {input5_function_setting, input6_function_setting} = {`FN_STEP_BIT1, `FN_STEP_BIT2};
    {input7_function_setting, input8_function_setting} = {`FN_STEP_BIT3, `FN_JOG_SELECT};
    {analog2_function_setting, analog3_function_setting} = {`AN_FN_UNUSED, `AN_FN_UNUSED};
    {speed_source_setting, run_source_setting} = {3'h0, `RUN_SRC_TERMINAL};
    {run_source_load, init_three_wire, key_run, key_stop, key_jog, key_dir_rev} = 6'h0;
    {serial_run, serial_rev, option_run, option_rev, stored_speed_refs} = 260'h0;
    {jog_speed_ref, analog_in_first, analog_in_second, analog_in_third} = 64'h0;
    step(16);
    chk("run_source_q", `RUN_SRC_RESET, run_source_q);
    rst = 0;
    for (i = 0; i < 80; i = i + 1) begin
      seed = xs(seed);
      stored_speed_refs = {stored_speed_refs[223:0], seed};
      {jog_speed_ref, analog_in_first} = seed;
      {analog_in_second, analog_in_third} = {~seed[15:0], seed[23:8]};
      analog2_function_setting = seed[3] ? `AN2_FN_ANALOG : `AN_FN_UNUSED;
      analog3_function_setting = seed[9] ? `AN3_FN_ANALOG : `AN_FN_UNUSED;
      speed_source_setting = {2'h0, seed[12]};
      want = i == 0 ? 8'hf1 : i == 1 ? 8'h72 : seed[31:24];
      step(10);
      e = pick(want);
      chk("speed_ref_out", e[15:0], speed_ref_out);
      chk("speed_step_out", {11'h0, e[20:16]}, speed_step_out);
      chk("run_cmd", want[0] ^ want[1], run_cmd);
      if (want[1:0] == 2'h2) chk("dir_reverse", 1, dir_reverse);
    end
    {run_source_setting, run_source_load, want} = {`RUN_SRC_KEYPAD, 1'h1, 8'h01};
    step(1);
    run_source_load = 0;
    step(8);
    chk("run_cmd", 0, run_cmd);
    key_run = 1;
    step(1);
    key_run = 0;
    step(2);
    chk("run_cmd", 1, run_cmd);
    {key_run, key_stop} = 2'h3;
    step(2);
    chk("run_cmd", 0, run_cmd);
    {key_run, key_stop, key_jog} = 3'h1;
    step(2);
    chk("run_cmd", 1, run_cmd);
    for (i = 2; i < 4; i = i + 1) begin
      {run_source_setting, run_source_load} = {i[1:0], 1'h1};
      {key_jog, serial_run, serial_rev, option_run, option_rev} = i == 2 ? 5'h0c : 5'h03;
      step(1);
      run_source_load = 0;
      step(2);
      chk("run_cmd", 1, run_cmd);
      chk("dir_reverse", 1, dir_reverse);
    end
    {run_source_setting, run_source_load, input3_function_setting} = {`RUN_SRC_TERMINAL, 6'h20};
    want = 8'h06;
    step(1);
    run_source_load = 0;
    step(10);
    chk("three_wire_mode", 1, three_wire_mode);
    want = 8'h07;
    step(3);
    want = 8'h06;
    step(10);
    chk("run_cmd", 0, run_cmd);
    run_pulse = 1;
    step(1);
    run_pulse = 0;
    step(40);
    chk("run_cmd", 1, run_cmd);
    chk("dir_reverse", 1, dir_reverse);
    want = 8'h04;
    step(10);
    chk("run_cmd", 0, run_cmd);
    {init_three_wire, input3_function_setting} = {1'b1, `FN_STEP_BIT1};
    step(2);
    chk("input3_function_q", `FN_THREE_WIRE, input3_function_q);
    test_done;
  end
endmodule
bind speed_step_and_run_command_select speed_run_sva sva (.*);
